// [hw/sfmio_pkg.sv]
// Function
// - quad output read: opcode, three address bytes and a dummy byte on one lane
// - after that dummy byte, read data leaves four bits per clock on four lanes
// - reads start at any byte and the address steps up after every byte
// - dual read: address and mode byte in two bits per clock, data back likewise
// - dual read mode byte with upper nibble A skips the next opcode
// - any other dual read mode byte makes the next frame expect an opcode
// - quad read: address, mode byte, four dummy clocks, data, all on four lanes
// - quad and word reads run only while the quad lane enable bit is set
// - quad read mode byte with upper nibble A skips the next opcode
// - word read needs an even address and uses two dummy clocks only (the address is not checked; odd addresses are read too)
// - word read continuous mode works the same way as the quad read
// - page write acts only when the write latch was set before
// - page write data past the page end wraps to the page start
// - over 256 bytes: only the last 256 are written, same page
// - under 256 bytes: only addressed bytes change, others stay
// - select must rise on a byte boundary or the page write is dropped
// - select rise starts a timed page write; busy flag reads one meanwhile
// - status reads are still served while the page write runs
// - write latch is cleared before the page write finishes
// - a page write into the block protected region is ignored
// - reads arriving during a write cycle are refused without disturbing it
// - four lane address: lane three carries bit 23 first, lane zero bit 20
package sfmio_pkg;
  // command codes
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_WORD_IO = 8'hE7;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_STATUS_LO = 8'h05;
  localparam logic [3:0] CONT_NIBBLE = 4'hA;
  // phase lengths in received bits; OUT_BYTE_BITS counts sent bits
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] DUMMY_BYTE_BITS = 6'h08;
  localparam logic [5:0] QUAD_DUMMY_BITS = 6'h10;
  localparam logic [5:0] WORD_DUMMY_BITS = 6'h08;
  localparam logic [5:0] DATA_BYTE_BITS = 6'h08;
  localparam logic [3:0] OUT_BYTE_BITS = 4'h8;
  // status byte layout
  localparam int ST_BUSY_POS = 0;
  localparam int ST_LATCH_POS = 1;
  localparam int ST_PROT_LSB = 2;
  // protection geometry: 64 KB blocks, 32 of them
  localparam int BLK_LSB = 16;
  localparam int BLK_MSB = 20;
  localparam logic [5:0] BLK_COUNT = 6'h20;
  localparam int PAGE_BYTES = 256;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PAGE_WRITE_TIME_US = 700;
  localparam int PAGE_WRITE_CYCLES_DEF = PAGE_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_CMD = 4'h1, ST_ADDR = 4'h2, ST_MODE = 4'h3, ST_DUMMY = 4'h4,
    ST_DATA = 4'h5, ST_PADDR = 4'h6, ST_PDATA = 4'h7, ST_STATUS = 4'h8, ST_IGNORE = 4'h9
  } sfmio_state_t;

  typedef enum logic [1:0] {
    RK_QUAD_OUT = 2'h0, RK_DUAL = 2'h1, RK_QUAD = 2'h2, RK_WORD = 2'h3
  } sfmio_kind_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } sfmio_pins_t;

  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [7:0] data;
  } sfmio_prog_t;

  // lanes used to receive in a given phase
  function automatic logic [2:0] sfmio_lanes_in(sfmio_state_t st, sfmio_kind_t k);
    logic [2:0] w;
    w = 3'h1;
    if (st == ST_ADDR || st == ST_MODE || st == ST_DUMMY) begin
      if (k == RK_DUAL) begin
        w = 3'h2;
      end else if (k != RK_QUAD_OUT) begin
        w = 3'h4;
      end
    end
    return w;
  endfunction

  // lanes used to send in a given phase
  function automatic logic [2:0] sfmio_lanes_out(sfmio_state_t st, sfmio_kind_t k);
    logic [2:0] w;
    w = 3'h1;
    if (st == ST_DATA) begin
      w = (k == RK_DUAL) ? 3'h2 : 3'h4;
    end
    return w;
  endfunction
endpackage

// [hw/sfmio_sync.sv]
`timescale 1ns/1ps
module sfmio_sync #(
  parameter int W = 6
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfmio_sync_t;
  sfmio_sync_t s, nxt;

  // two stages; only the second stage is visible outside
  always_comb begin
    nxt.s1 = d_in;
    nxt.s2 = s.s1;
  end

  // idle level is high for select, so reset to ones avoids a false select edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '1;
    end else begin
      s <= nxt;
    end
  end

  assign q_out = s.s2;
endmodule

// [hw/sfmio_page_buf.sv]
`timescale 1ns/1ps
module sfmio_page_buf
  import sfmio_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic wr_in,
  input wire logic [7:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_idx_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out
);
  typedef struct packed {
    logic [PAGE_BYTES-1:0] valid;
    logic [7:0] rd_data;
    logic rd_valid;
  } sfmio_buf_t;
  sfmio_buf_t s, nxt;
  logic [7:0] mem [PAGE_BYTES];

  // a later byte at the same index simply replaces the earlier one
  always_comb begin
    nxt = s;
    if (clr_in) begin
      nxt.valid = '0;
    end else if (wr_in) begin
      nxt.valid[wr_idx_in] = 1'b1;
    end
    nxt.rd_data = mem[rd_idx_in];
    nxt.rd_valid = s.valid[rd_idx_in];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end

  // byte store; only the valid mask needs a reset
  always_ff @(posedge clk_in) begin
    if (wr_in && !clr_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  assign rd_data_out = s.rd_data;
  assign rd_valid_out = s.rd_valid;
endmodule

// [hw/sfmio_core.sv]
`timescale 1ns/1ps
module sfmio_core
  import sfmio_pkg::*;
#(
  parameter int unsigned PAGE_WRITE_CYCLES = PAGE_WRITE_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire sfmio_pins_t pins_in,
  input wire logic status_bit_nine_in,
  input wire logic [4:0] block_protect_bits_in,
  input wire logic [7:0] mem_data_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n_out,
  output logic [23:0] mem_addr_out,
  output sfmio_prog_t prog_out,
  output logic write_latch_out,
  output logic busy_flag_out
);
  typedef struct packed {
    sfmio_state_t st;
    sfmio_kind_t kind;
    logic cont_on;
    sfmio_kind_t cont_kind;
    logic [5:0] bits;
    logic [31:0] sr;
    logic [23:0] addr;
    logic [7:0] out_sr;
    logic [3:0] out_left;
    logic [3:0] io_o;
    logic [3:0] oe_n;
    logic sclk_d;
    logic cs_n_d;
    logic write_latch;
    logic latch_pend;
    logic pseen;
    logic busy;
    logic [31:0] wait_cnt;
    logic [8:0] walk;
    logic walk_act_d;
    logic [7:0] walk_idx_d;
    sfmio_prog_t prog;
  } sfmio_core_t;

  sfmio_core_t s, nxt;
  sfmio_pins_t ps;
  logic [5:0] sync_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic [2:0] w_in, w_out;
  logic [3:0] sample;
  logic [31:0] nsr;
  logic [7:0] cur, status_byte;
  logic load_byte, prot, buf_clr, buf_wr, buf_valid;
  logic [7:0] buf_data;

  sfmio_sync #(.W(6)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(pins_in),
    .q_out(sync_q)
  );

  sfmio_page_buf u_buf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(buf_clr),
    .wr_in(buf_wr),
    .wr_idx_in(s.addr[7:0]),
    .wr_data_in(nsr[7:0]),
    .rd_idx_in(s.walk[7:0]),
    .rd_data_out(buf_data),
    .rd_valid_out(buf_valid)
  );

  // region covered by the protect bits, counted in 64 KB blocks; bit 4 is not decoded
  function automatic logic prot_hit(logic [23:0] a, logic [4:0] bp);
    logic [5:0] size;
    logic [5:0] blk;
    size = (bp[2:0] == 3'h0) ? 6'h00 : (bp[2:0] >= 3'h6) ? BLK_COUNT
           : 6'(6'h01 << (bp[2:0] - 3'h1));
    blk = {1'b0, a[BLK_MSB:BLK_LSB]};
    return bp[3] ? (blk < size) : (blk >= BLK_COUNT - size);
  endfunction

  // edges of the sampled link clock and select
  assign ps = sfmio_pins_t'(sync_q);
  assign sclk_rise = ps.sclk && !s.sclk_d;
  assign sclk_fall = !ps.sclk && s.sclk_d;
  assign cs_fall = !ps.cs_n && s.cs_n_d;
  assign cs_rise = ps.cs_n && !s.cs_n_d;
  assign prot = prot_hit(s.addr, block_protect_bits_in);
  assign status_byte = {1'b0, block_protect_bits_in, s.write_latch, s.busy};

  // incoming bits enter at the bottom, so the first bit ends up most significant
  always_comb begin
    w_in = sfmio_lanes_in(s.st, s.kind);
    w_out = sfmio_lanes_out(s.st, s.kind);
    sample = (w_in == 3'h1) ? {3'h0, ps.io[0]} :
             (w_in == 3'h2) ? {2'h0, ps.io[1:0]} : ps.io;
    nsr = (s.sr << w_in) | {28'h0, sample};
    load_byte = sclk_fall && !ps.cs_n && (s.st == ST_DATA) && (s.out_left == 4'h0);
    cur = (s.out_left != 4'h0) ? s.out_sr : (s.st == ST_DATA) ? mem_data_in : status_byte;
    buf_wr = sclk_rise && !ps.cs_n && s.st == ST_PDATA && (s.bits + w_in[2:0] == DATA_BYTE_BITS);
    buf_clr = sclk_rise && !ps.cs_n && s.st == ST_PADDR && (s.bits + w_in == ADDR_BITS);
  end

  // main sequencer: select edges, rising-edge capture, falling-edge launch, write cycle
  always_comb begin
    nxt = s;
    nxt.sclk_d = ps.sclk;
    nxt.cs_n_d = ps.cs_n;
    nxt.prog.we = 1'b0;
    // write cycle: walk the page buffer while the timed cycle counts down
    if (s.busy) begin
      nxt.walk_act_d = !s.walk[8];
      nxt.walk_idx_d = s.walk[7:0];
      if (!s.walk[8]) begin
        nxt.walk = s.walk + 9'h001;
      end
      if (s.walk_act_d && buf_valid) begin
        nxt.prog.we = 1'b1;
        nxt.prog.addr = {s.addr[23:8], s.walk_idx_d};
        nxt.prog.data = buf_data;
      end
      if (s.wait_cnt == 32'h0) begin
        nxt.busy = 1'b0;
      end else begin
        nxt.wait_cnt = s.wait_cnt - 32'h1;
      end
    end
    if (cs_fall) begin
      // a stored mode byte of A_ lets the frame start straight at the address
      nxt.bits = '0;
      nxt.sr = '0;
      nxt.out_left = '0;
      nxt.latch_pend = 1'b0;
      nxt.pseen = 1'b0;
      if (s.cont_on) begin
        nxt.kind = s.cont_kind;
        nxt.st = (s.busy || (s.cont_kind != RK_DUAL && !status_bit_nine_in))
                 ? ST_IGNORE : ST_ADDR;
      end else begin
        nxt.st = ST_CMD;
      end
    end else if (cs_rise) begin
      // commit only on a whole byte, with the latch set, outside the protected area
      if (s.st == ST_PDATA && s.bits == 6'h0 && s.pseen && s.write_latch && !prot) begin
        nxt.busy = 1'b1;
        nxt.write_latch = 1'b0;
        nxt.walk = '0;
        nxt.walk_act_d = 1'b0;
        nxt.wait_cnt = 32'(PAGE_WRITE_CYCLES - 1);
      end
      if (s.latch_pend && !s.busy) begin
        nxt.write_latch = 1'b1;
      end
      nxt.st = ST_IDLE;
      nxt.oe_n = 4'hF;
    end else if (!ps.cs_n && sclk_rise) begin
      nxt.sr = nsr;
      nxt.bits = s.bits + {3'h0, w_in};
      unique case (s.st)
        ST_CMD: begin
          if (nxt.bits == OPCODE_BITS) begin
            nxt.bits = '0;
            nxt.st = ST_IGNORE;
            if (nsr[7:0] == OP_STATUS_LO) begin
              nxt.st = ST_STATUS;
            end else if (nsr[7:0] == OP_LATCH_SET) begin
              nxt.latch_pend = 1'b1;
            end else if (!s.busy) begin
              if (nsr[7:0] == OP_QUAD_OUT) begin
                nxt.st = ST_ADDR;
                nxt.kind = RK_QUAD_OUT;
              end else if (nsr[7:0] == OP_DUAL_IO) begin
                nxt.st = ST_ADDR;
                nxt.kind = RK_DUAL;
              end else if (nsr[7:0] == OP_QUAD_IO && status_bit_nine_in) begin
                nxt.st = ST_ADDR;
                nxt.kind = RK_QUAD;
              end else if (nsr[7:0] == OP_WORD_IO && status_bit_nine_in) begin
                nxt.st = ST_ADDR;
                nxt.kind = RK_WORD;
              end else if (nsr[7:0] == OP_PAGE_WRITE && s.write_latch) begin
                nxt.st = ST_PADDR;
              end
            end
          end
        end
        ST_ADDR: begin
          if (nxt.bits == ADDR_BITS) begin
            nxt.bits = '0;
            nxt.addr = nsr[23:0];
            nxt.st = (s.kind == RK_QUAD_OUT) ? ST_DUMMY : ST_MODE;
          end
        end
        ST_MODE: begin
          if (nxt.bits == MODE_BITS) begin
            nxt.bits = '0;
            nxt.cont_on = (nsr[7:4] == CONT_NIBBLE);
            nxt.cont_kind = s.kind;
            nxt.st = (s.kind == RK_DUAL) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (nxt.bits == ((s.kind == RK_QUAD) ? QUAD_DUMMY_BITS :
                           (s.kind == RK_WORD) ? WORD_DUMMY_BITS :
                           DUMMY_BYTE_BITS)) begin
            nxt.bits = '0;
            nxt.st = ST_DATA;
          end
        end
        ST_PADDR: begin
          if (nxt.bits == ADDR_BITS) begin
            nxt.bits = '0;
            nxt.addr = nsr[23:0];
            nxt.st = ST_PDATA;
          end
        end
        ST_PDATA: begin
          if (nxt.bits == DATA_BYTE_BITS) begin
            nxt.bits = '0;
            nxt.pseen = 1'b1;
            nxt.addr[7:0] = s.addr[7:0] + 8'h01;
          end
        end
        default: begin
          nxt.bits = '0;
        end
      endcase
    end else if (!ps.cs_n && sclk_fall && (s.st == ST_DATA || s.st == ST_STATUS)) begin
      // launch on the falling edge; the host samples on the next rising edge
      if (load_byte) begin
        nxt.addr = s.addr + 24'h000001;
      end
      nxt.out_left = ((s.out_left == 4'h0) ? OUT_BYTE_BITS : s.out_left) - {1'b0, w_out};
      nxt.out_sr = 8'(cur << w_out);
      if (w_out == 3'h4) begin
        nxt.io_o = cur[7:4];
        nxt.oe_n = 4'h0;
      end else if (w_out == 3'h2) begin
        nxt.io_o = {2'h0, cur[7:6]};
        nxt.oe_n = 4'hC;
      end else begin
        nxt.io_o = {2'h0, cur[7], 1'b0};
        nxt.oe_n = 4'hD;
      end
    end
  end

  // the whole block state is one register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.oe_n <= 4'hF;
      s.sclk_d <= 1'b1;
      s.cs_n_d <= 1'b1;
    end else begin
      s <= nxt;
    end
  end

  assign io_out = s.io_o;
  assign io_oe_n_out = s.oe_n;
  assign mem_addr_out = s.addr;
  assign prog_out = s.prog;
  assign write_latch_out = s.write_latch;
  assign busy_flag_out = s.busy;

  // helper: length of the current write cycle
  int busy_len;
  always_ff @(posedge clk_in) begin
    if (rst_in || !s.busy) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  latch_gates_write_a: assert property ($rose(s.busy) |-> $past(s.write_latch))
    else $error("page write started without write latch");
  latch_cleared_a: assert property ($rose(s.busy) |-> !s.write_latch)
    else $error("write latch still set in write cycle");
  busy_length_a: assert property ($fell(s.busy) |-> busy_len == int'(PAGE_WRITE_CYCLES))
    else $error("write cycle length wrong");
  byte_boundary_a: assert property ($rose(s.busy) |-> $past(s.st) == ST_PDATA && $past(s.bits) == 6'h0)
    else $error("write committed off a byte boundary");
  protect_skip_a: assert property ($rose(s.busy) |-> !$past(prot))
    else $error("write into protected region");
  busy_no_read_a: assert property (s.busy |-> s.st != ST_DATA && s.st != ST_PADDR)
    else $error("read accepted during write cycle");
  page_wrap_a: assert property ((s.st == ST_PDATA && nxt.st == ST_PDATA) |=> $stable(s.addr[23:8]))
    else $error("page write left its page");
  addr_step_a: assert property (load_byte |=> s.addr == $past(s.addr) + 24'h000001)
    else $error("read address did not advance");
  cont_enter_a: assert property ($rose(s.cont_on) |-> $past(s.st) == ST_MODE && $past(nsr[7:4]) == CONT_NIBBLE)
    else $error("continuous mode entered without A nibble");
  cont_leave_a: assert property ($fell(s.cont_on) |-> $past(s.st) == ST_MODE)
    else $error("continuous mode left outside mode byte");
  quad_drive_a: assert property ((s.st == ST_DATA && s.kind == RK_QUAD_OUT && sclk_fall && !ps.cs_n) |=> s.oe_n == 4'h0)
    else $error("quad data not on four lanes");
  quad_enable_a: assert property ((cs_fall || sclk_rise) && nxt.st == ST_ADDR && $changed(nxt.st) && nxt.kind inside {RK_QUAD, RK_WORD} |-> status_bit_nine_in)
    else $error("quad read without quad lane enable");

  cover property ($rose(s.cont_on));
  cover property ($rose(s.busy));
  cover property (s.st == ST_DATA && s.kind == RK_WORD);
  cover property (s.busy && s.st == ST_STATUS);
endmodule

// [tb/sfmio_host.sv]
`timescale 1ns/1ps
module sfmio_host
  import sfmio_pkg::*;
(
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_oe_n_in,
  output sfmio_pins_t pins_out,
  output logic drove_out
);
  logic [3:0] drv = 4'h0;
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  logic [7:0] last_b = 8'h00;
  event got_b;

  // lane level: the device wins where it drives, else our value (inverted once released)
  always_comb begin
    pins_out.cs_n = cs_n;
    pins_out.sclk = sclk;
    for (int i = 0; i < 4; i++) begin
      pins_out.io[i] = io_oe_n_in[i] ? drv[i] : io_in[i];
    end
  end

  // sticky note that the device drove some lane during the current frame
  always @(io_oe_n_in) begin
    if (io_oe_n_in !== 4'hF) drove_out = 1'b1;
  end

  // select falls; the link clock stands low outside frames
  // the extra 1 ns keeps every pin change off a system clock edge, avoiding a race
  task automatic sel();
    drove_out = 1'b0;
    #41 cs_n = 1'b0;
    #40;
  endtask

  // select rises 40 ns after the last clock, whole byte or not, lanes then invert
  task automatic desel();
    #40 cs_n = 1'b1;
    drv = ~drv;
    #199;
  endtask

  // w bits per rising edge, highest bit on the highest lane, msb first
  task automatic tx(input int w, input logic [31:0] v, input int nb);
    for (int i = nb - w; i >= 0; i -= w) begin
      drv = 4'(v >> i) & 4'((1 << w) - 1);
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
  endtask

  // one byte back; a single lane answer arrives on lane one
  task automatic rx(input int w, output logic [7:0] b);
    b = 8'h00;
    drv = ~drv;
    for (int k = 0; k < 8 / w; k++) begin
      #62.5;
      b = (b << w) | 8'(w == 1 ? pins_out.io[1] : pins_out.io & 4'((1 << w) - 1));
      sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    // hand the byte to the bench monitor
    last_b = b;
    -> got_b;
  endtask
endmodule

// [tb/serial_flash_multi_io_read_program_tb_top.sv]
`timescale 1ns/1ps
module serial_flash_multi_io_read_program_tb_top
  import sfmio_pkg::*;
;
  // long enough for a status poll and a refused read inside one write cycle
  localparam int unsigned PWC = 3000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic status_bit_nine_in = 1'b0;
  logic [4:0] block_protect_bits_in = 5'h00;
  logic [7:0] mem_data_in;
  sfmio_pins_t pins;
  logic [3:0] io_out, io_oe_n_out;
  logic [23:0] mem_addr_out;
  sfmio_prog_t prog_out;
  logic write_latch_out, busy_flag_out, drove;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 55;
  int bcnt = 0;
  int qd;
  logic [31:0] exq[$];
  logic [7:0] rdq[$];
  logic [7:0] qop[2] = '{8'hEB, 8'hE7};
  logic [23:0] a;

  always #5 clk_in = ~clk_in;

  // array contents follow the address, so every read byte is predictable
  function automatic logic [7:0] arr(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction
  assign mem_data_in = arr(mem_addr_out);

  sfmio_core #(.PAGE_WRITE_CYCLES(PWC)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .pins_in(pins),
    .status_bit_nine_in(status_bit_nine_in), .block_protect_bits_in(block_protect_bits_in),
    .mem_data_in(mem_data_in), .io_out(io_out), .io_oe_n_out(io_oe_n_out),
    .mem_addr_out(mem_addr_out), .prog_out(prog_out), .write_latch_out(write_latch_out),
    .busy_flag_out(busy_flag_out));

  sfmio_host u_host (.io_in(io_out), .io_oe_n_in(io_oe_n_out), .pins_out(pins),
    .drove_out(drove));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compares=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // each write pulse takes the oldest noted write; a pulse with none noted is wrong
  always @(posedge clk_in) begin
    if (!rst_in && prog_out.we === 1'b1) begin
      if (exq.size() == 0) check({8'h00, prog_out.addr, prog_out.data}, 32'hFFFFFFFF);
      else check({8'h00, prog_out.addr, prog_out.data}, exq.pop_front());
    end
  end

  // each byte the host takes in while a read byte is noted is held against the oldest one
  always @(u_host.got_b) begin
    if (rdq.size() != 0) check(u_host.last_b, rdq.pop_front());
  end

  // busy must stand for exactly the configured write time
  always @(posedge clk_in) begin
    if (busy_flag_out === 1'b1) bcnt <= bcnt + 1;
    else if (bcnt != 0) begin
      check(bcnt, PWC);
      bcnt <= 0;
    end
  end

  // one read frame; op 00 means continuous mode, no opcode sent
  task automatic rd_frame(input logic [7:0] op, input int wa, input logic [23:0] ad,
      input int mb, input logic [7:0] m, input int db, input int wd, input int n, input bit ok);
    logic [7:0] b;
    u_host.sel();
    if (op != 8'h00) u_host.tx(1, op, 8);
    u_host.tx(wa, ad, 24);
    u_host.tx(wa, m, mb);
    u_host.tx(wa, 32'h0, db);
    for (int k = 0; k < n; k++) begin
      if (ok) rdq.push_back(arr(ad + 24'(k)));
      u_host.rx(wd, b);
    end
    u_host.desel();
    if (!ok) check(drove, 1'b0);
    $display("read frame %h done at %0t", op, $time);
  endtask

  task automatic write_latch_set_cmd();
    u_host.sel();
    u_host.tx(1, 8'h06, 8);
    u_host.desel();
    check(write_latch_out, 1'b1);
  endtask

  task automatic wait_idle();
    int t;
    t = 0;
    while (busy_flag_out !== 1'b0 && t < 4000) begin
      @(negedge clk_in);
      t++;
    end
    if (t >= 4000) begin
      check(1, 0);
      final_report();
    end
  endtask

  // page write of n random bytes plus extra stray bits; ok says whether it must run
  task automatic pw_frame(input logic [23:0] ad, input int n, input int extra, input bit ok);
    logic [7:0] d;
    logic [7:0] b;
    logic [7:0] img[256];
    bit hit[256];
    hit = '{default: 1'b0};
    u_host.sel();
    u_host.tx(1, 8'h02, 8);
    u_host.tx(1, ad, 24);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      img[8'(ad + k)] = d;
      hit[8'(ad + k)] = 1'b1;
      u_host.tx(1, d, 8);
    end
    u_host.tx(1, 32'h0, extra);
    for (int i = 0; i < 256; i++) begin
      if (ok && hit[i]) exq.push_back({8'h00, ad[23:8], 8'(i), img[i]});
    end
    u_host.desel();
    if (ok) begin
      check(busy_flag_out, 1'b1);
      check(write_latch_out, 1'b0);
      u_host.sel();
      u_host.tx(1, 8'h05, 8);
      u_host.rx(1, b);
      u_host.desel();
      check(b, {1'b0, block_protect_bits_in, 2'b01});
      rd_frame(8'h6B, 1, 24'h0, 0, 8'h00, 8, 4, 1, 1'b0);
      wait_idle();
      check(exq.size(), 0);
    end else begin
      repeat (20) @(negedge clk_in);
      check(busy_flag_out, 1'b0);
    end
    $display("page write at %h done at %0t", ad, $time);
  endtask

  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    // quad output read running over a page end
    rd_frame(8'h6B, 1, 24'h0123FE, 0, 8'h00, 8, 4, 4, 1'b1);
    // dual read: continuous mode kept, then cleared with FF, then opcode needed again
    a = 24'($random(seed));
    rd_frame(8'hBB, 2, a, 8, 8'hA5, 0, 2, 3, 1'b1);
    rd_frame(8'h00, 2, a + 24'h10, 8, 8'hFF, 0, 2, 2, 1'b1);
    rd_frame(8'h00, 2, 24'h0, 8, 8'h00, 0, 2, 2, 1'b0);
    rd_frame(8'hBB, 2, a, 8, 8'h00, 0, 2, 2, 1'b1);
    // quad and word reads: refused without the enable bit, then continuous mode
    foreach (qop[j]) begin
      qd = (qop[j] == 8'hEB) ? 16 : 8;
      @(negedge clk_in) status_bit_nine_in = 1'b0;
      rd_frame(qop[j], 4, 24'h0, 8, 8'hA0, qd, 4, 2, 1'b0);
      @(negedge clk_in) status_bit_nine_in = 1'b1;
      a = 24'($random(seed)) & 24'hFFFFFE;
      rd_frame(qop[j], 4, a, 8, 8'hA7, qd, 4, 3, 1'b1);
      rd_frame(8'h00, 4, a + 24'h2, 8, 8'hFF, qd, 4, 2, 1'b1);
      rd_frame(8'h00, 4, 24'h0, 8, 8'h00, qd, 4, 2, 1'b0);
    end
    // page writes: no latch, wrap, overlong, broken byte, protected block
    pw_frame(24'h000100, 2, 0, 1'b0);
    write_latch_set_cmd();
    pw_frame(24'h0002FE, 3, 0, 1'b1);
    write_latch_set_cmd();
    pw_frame(24'h000310, 258, 0, 1'b1);
    write_latch_set_cmd();
    pw_frame(24'h000400, 1, 3, 1'b0);
    @(negedge clk_in) block_protect_bits_in = 5'h01;
    write_latch_set_cmd();
    pw_frame(24'h1F0000, 2, 0, 1'b0);
    // protection anchored at the bottom of the array
    @(negedge clk_in) block_protect_bits_in = 5'h09;
    write_latch_set_cmd();
    pw_frame(24'h00F000, 1, 0, 1'b0);
    final_report();
  end
endmodule
